// File: logic/pmc_pkg.sv
package pmc_pkg;

    // Minimum reset pulse length and management init time.
    localparam int RESET_MIN_NS = 10000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_NS = 40000;
    localparam int INIT_CYC = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] RESET_MIN_CNT = CNT_W'(RESET_MIN_CYC);
    localparam logic [CNT_W-1:0] INIT_CNT = CNT_W'(INIT_CYC);

    typedef enum logic [1:0] {
        PMC_INIT,
        PMC_LOW_POWER,
        PMC_HIGH_POWER
    } pmc_state_t;

endpackage

// File: logic/pmc_fault_if.sv
`timescale 1ns/1ns
interface pmc_fault_if;
    logic fault_event;
    logic status_read;
    logic pending;
    logic clear;
    modport owner (input fault_event, input status_read, input clear,
                   output pending);
    modport user (output fault_event, output status_read, output clear,
                  input pending);
endinterface

// File: logic/pmc_flag.sv
`timescale 1ns/1ns
module pmc_flag (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Flag access
    pmc_fault_if.owner flag
);

    typedef struct packed {
        logic pend;
    } pmc_flag_state_t;

    pmc_flag_state_t st_q;
    pmc_flag_state_t st_d;

    // A new event in the clearing cycle wins over the clear.
    always_comb begin
        st_d = st_q;
        if (flag.clear || flag.status_read) begin
            st_d.pend = 1'b0;
        end
        if (flag.fault_event) begin
            st_d.pend = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag.pending = st_q.pend;

endmodule

// File: logic/pmc_ctrl.sv
`timescale 1ns/1ns
module pmc_ctrl (
    // Clock and power-up reset
    input wire logic core_clk,
    input wire logic reset,
    // Host control pins
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic init_control_select,
    input wire logic init_control_driven,
    // Serial core requests from the management engine, software power enable, status read and fault event
    input wire logic serial_ack_req,
    input wire logic serial_sda_low_req,
    input wire logic sw_high_power_en,
    input wire logic status_read,
    input wire logic fault_event,
    // Pin outputs
    output logic serial_sda_o,
    output logic serial_sda_oe,
    output logic serial_ack,
    output logic module_present_n,
    output logic host_interrupt_n_o,
    output logic host_interrupt_n_oe,
    output logic low_power_select,
    output logic data_not_ready
);

    typedef struct packed {
        pmc_pkg::pmc_state_t state;
        logic [pmc_pkg::CNT_W-1:0] rst_cnt;
        logic [pmc_pkg::CNT_W-1:0] init_cnt;
        logic done_pend;
        logic sda_oe;
        logic ack;
        logic int_oe;
        logic low_power;
        logic not_ready;
        logic present_n;
    } pmc_state_s_t;

    pmc_state_s_t st_q;
    pmc_state_s_t st_d;
    logic init_mode;
    logic reset_hit;

    pmc_fault_if fault_bus ();

    // The flag keeper lives apart so a second fault source can be added.
    pmc_flag u_flag (
        .core_clk(core_clk),
        .reset(reset),
        .flag(fault_bus.owner)
    );

    assign fault_bus.fault_event = fault_event;
    assign fault_bus.status_read = status_read;
    assign fault_bus.clear = reset_hit;

    // An undriven pin reads as the internal pull-up level.
    assign init_mode = init_control_driven ? init_control_select : 1'b1;
    assign reset_hit = !module_reset_n &&
        (st_q.rst_cnt == pmc_pkg::RESET_MIN_CNT);

    // ********************************************************
    // Control sequence
    // ********************************************************
    always_comb begin
        st_d = st_q;
        st_d.present_n = 1'b0;
        if (!module_reset_n) begin
            if (st_q.rst_cnt != pmc_pkg::RESET_MIN_CNT) begin
                st_d.rst_cnt = st_q.rst_cnt + pmc_pkg::CNT_ONE;
            end
        end else begin
            st_d.rst_cnt = pmc_pkg::CNT_ZERO;
        end
        // A read in the completion cycle loses to the new completion.
        if (status_read) begin
            st_d.done_pend = 1'b0;
        end
        case (st_q.state)
            pmc_pkg::PMC_INIT: begin
                st_d.low_power = 1'b1;
                st_d.not_ready = 1'b1;
                if (st_q.init_cnt == pmc_pkg::INIT_CNT) begin
                    st_d.not_ready = 1'b0;
                    st_d.done_pend = 1'b1;
                    if (init_mode) begin
                        st_d.state = pmc_pkg::PMC_LOW_POWER;
                    end else begin
                        st_d.state = pmc_pkg::PMC_HIGH_POWER;
                        st_d.low_power = 1'b0;
                    end
                end else begin
                    st_d.init_cnt = st_q.init_cnt + pmc_pkg::CNT_ONE;
                end
            end
            pmc_pkg::PMC_LOW_POWER: begin
                if (sw_high_power_en) begin
                    st_d.state = pmc_pkg::PMC_HIGH_POWER;
                    st_d.low_power = 1'b0;
                end
            end
            pmc_pkg::PMC_HIGH_POWER: begin
                if (init_mode && !sw_high_power_en) begin
                    st_d.state = pmc_pkg::PMC_LOW_POWER;
                    st_d.low_power = 1'b1;
                end
            end
            default: begin
                st_d.state = pmc_pkg::PMC_INIT;
            end
        endcase
        // Reset takes the whole sequence back to its defaults.
        if (reset_hit) begin
            st_d.state = pmc_pkg::PMC_INIT;
            st_d.init_cnt = pmc_pkg::CNT_ZERO;
            st_d.done_pend = 1'b0;
            st_d.low_power = 1'b1;
            st_d.not_ready = 1'b1;
        end
        // Serial answers only while selected; the bus is released otherwise.
        st_d.ack = !module_select_n && serial_ack_req;
        st_d.sda_oe = !module_select_n &&
            (serial_ack_req || serial_sda_low_req);
        // A full reset drops a pending fault at once, not a cycle late.
        st_d.int_oe = (st_d.done_pend && !st_d.not_ready) ||
            (fault_bus.pending && !reset_hit);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
            st_q.state <= pmc_pkg::PMC_INIT;
            st_q.low_power <= 1'b1;
            st_q.not_ready <= 1'b1;
            st_q.present_n <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Open drain: the output value is always low; only the enable moves.
    assign serial_sda_o = 1'b0;
    assign serial_sda_oe = st_q.sda_oe;
    assign serial_ack = st_q.ack;
    assign host_interrupt_n_o = 1'b0;
    assign host_interrupt_n_oe = st_q.int_oe;
    assign module_present_n = st_q.present_n;
    assign low_power_select = st_q.low_power;
    assign data_not_ready = st_q.not_ready;

    // ********************************************************
    // Checks
    // ********************************************************
    property p_sel_gate;
        @(posedge core_clk) disable iff (reset)
        module_select_n |=> !serial_sda_oe && !serial_ack;
    endproperty
    a_sel_gate: assert property (p_sel_gate)
        else $error("Serial line driven while deselected.");

    property p_sel_ack;
        @(posedge core_clk) disable iff (reset)
        !module_select_n && serial_ack_req |=> serial_ack;
    endproperty
    a_sel_ack: assert property (p_sel_ack)
        else $error("Selected request not acknowledged.");

    property p_reset_back;
        @(posedge core_clk) disable iff (reset)
        reset_hit |=> data_not_ready && low_power_select;
    endproperty
    a_reset_back: assert property (p_reset_back)
        else $error("Reset did not restore defaults.");

    property p_done_int;
        @(posedge core_clk) disable iff (reset)
        $fell(data_not_ready) |-> host_interrupt_n_oe;
    endproperty
    a_done_int: assert property (p_done_int)
        else $error("No completion interrupt.");

    property p_int_ready;
        @(posedge core_clk) disable iff (reset)
        host_interrupt_n_oe && !fault_bus.pending |-> !data_not_ready;
    endproperty
    a_int_ready: assert property (p_int_ready)
        else $error("Completion interrupt while not ready.");

    property p_sw_hold;
        @(posedge core_clk) disable iff (reset)
        st_q.state == pmc_pkg::PMC_LOW_POWER && !sw_high_power_en
            |=> low_power_select;
    endproperty
    a_sw_hold: assert property (p_sw_hold)
        else $error("Left low power without software.");

    property p_hw_up;
        @(posedge core_clk) disable iff (reset)
        $fell(data_not_ready) && !init_mode |-> !low_power_select;
    endproperty
    a_hw_up: assert property (p_hw_up)
        else $error("Hardware init did not reach high power.");

    property p_present;
        @(posedge core_clk) disable iff (reset)
        !module_present_n;
    endproperty
    a_present: assert property (p_present)
        else $error("Presence not grounded.");

    property p_fault;
        @(posedge core_clk) disable iff (reset)
        fault_event && !reset_hit ##1 !reset_hit |=> host_interrupt_n_oe;
    endproperty
    a_fault: assert property (p_fault)
        else $error("Fault did not assert interrupt.");

    property p_release;
        @(posedge core_clk) disable iff (reset)
        status_read && !fault_event && !reset_hit ##1 !fault_event
            |=> !host_interrupt_n_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("Interrupt not released after read.");

    c_hw: cover property (@(posedge core_clk) disable iff (reset)
        $fell(low_power_select) && !init_mode);
    c_sw: cover property (@(posedge core_clk) disable iff (reset)
        st_q.state == pmc_pkg::PMC_LOW_POWER ##1 sw_high_power_en);
    c_rst: cover property (@(posedge core_clk) disable iff (reset)
        reset_hit);

endmodule

// File: test/pmc_host_model.sv
`timescale 1ns/1ns
// ****************************************
// Host side: pull-ups and interrupt service.
// ****************************************
module pmc_host_model (
    // Clock
    input wire logic core_clk,
    // Service control
    input wire logic auto_service,
    input wire logic [7:0] service_delay,
    // Module pins and status
    input wire logic host_interrupt_n_o,
    input wire logic host_interrupt_n_oe,
    input wire logic serial_sda_o,
    input wire logic serial_sda_oe,
    input wire logic data_not_ready,
    // Resolved lines and read strobe
    output logic int_line_n,
    output logic sda_line,
    output logic status_read
);
    logic [7:0] wait_q;
    // The board pull-ups give the high level of both lines.
    assign int_line_n =
        host_interrupt_n_oe ? host_interrupt_n_o : 1'b1;
    assign sda_line = serial_sda_oe ? serial_sda_o : 1'b1;
    initial begin
        status_read = 1'b0;
        wait_q = 8'h00;
    end
    // A slow host lets the line sit low for a while before reading.
    always @(posedge core_clk) begin
        status_read <= 1'b0;
        if (auto_service && int_line_n === 1'b0 &&
            !data_not_ready) begin
            if (wait_q >= service_delay) begin
                status_read <= 1'b1;
                wait_q <= 8'h00;
            end else begin
                wait_q <= wait_q + 8'h01;
            end
        end else begin
            wait_q <= 8'h00;
        end
    end
endmodule

// File: test/tb_pluggable_module_control_pins.sv
`timescale 1ns/1ns
module tb_pluggable_module_control_pins;
    // ****************************************
    // Pins, counters and the design.
    // ****************************************
    logic core_clk, reset, module_select_n, module_reset_n;
    logic init_control_select, init_control_driven, serial_ack_req;
    logic serial_sda_low_req, sw_high_power_en, status_read, fault_event;
    logic serial_sda_o, serial_sda_oe, serial_ack, module_present_n;
    logic host_interrupt_n_o, host_interrupt_n_oe, low_power_select;
    logic data_not_ready, int_line_n, sda_line, auto_service;
    logic [7:0] service_delay;
    int err_count = 0;
    int compares = 0;
    pmc_ctrl u_dut (.core_clk, .reset, .module_select_n, .module_reset_n,
        .init_control_select, .init_control_driven, .serial_ack_req,
        .serial_sda_low_req, .sw_high_power_en, .status_read, .fault_event,
        .serial_sda_o, .serial_sda_oe, .serial_ack, .module_present_n,
        .host_interrupt_n_o, .host_interrupt_n_oe, .low_power_select,
        .data_not_ready);
    pmc_host_model u_host (.core_clk, .auto_service, .service_delay,
        .host_interrupt_n_o, .host_interrupt_n_oe, .serial_sda_o,
        .serial_sda_oe, .data_not_ready, .int_line_n, .sda_line,
        .status_read);
    always #20 core_clk = ~core_clk;
    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic check(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // The host waits dly cycles, so the line must hold that long.
    task automatic service(input logic [7:0] dly);
        int n;
        service_delay = dly;
        auto_service = 1'b1;
        n = 0;
        while (int_line_n !== 1'b1 && n < 64) begin
            @(negedge core_clk);
            n++;
        end
        auto_service = 1'b0;
        check("int_release", 1'b1, int_line_n);
        check("int_held", 1'b1, n > dly);
    endtask
    // A pin reset releases on its own timing, so only a bound is kept.
    task automatic power_up(input logic exp_lp, input logic timed);
        int n;
        n = 0;
        while (data_not_ready !== 1'b0 && n < 1200) begin
            @(negedge core_clk);
            n++;
        end
        check("init_done", 1'b1, n < pmc_pkg::INIT_CYC + 4);
        if (timed) check("init_early", 1'b1, n > pmc_pkg::INIT_CYC - 3);
        check("low_power", exp_lp, low_power_select);
        check("present_n", 1'b0, module_present_n);
        @(negedge core_clk);
        check("done_int", 1'b0, int_line_n);
        check("done_nrdy", 1'b0, data_not_ready);
        service(8'h03);
    endtask
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic serial_gate;
        for (int s = 1; s >= 0; s--) begin
            module_select_n = s[0];
            serial_ack_req = 1'b1;
            serial_sda_low_req = 1'b1;
            repeat (2) @(negedge core_clk);
            check("ack", ~s[0], serial_ack);
            check("sda", s[0], sda_line);
            serial_ack_req = 1'b0;
            repeat (2) @(negedge core_clk);
            check("ack_off", 1'b0, serial_ack);
            check("sda_low", s[0], sda_line);
            serial_sda_low_req = 1'b0;
            repeat (2) @(negedge core_clk);
            check("sda_free", 1'b1, sda_line);
        end
        module_select_n = 1'b1;
    endtask
    task automatic high_power;
        repeat (8) @(negedge core_clk);
        check("lp_hold", 1'b1, low_power_select);
        sw_high_power_en = 1'b1;
        repeat (3) @(negedge core_clk);
        check("lp_exit", 1'b0, low_power_select);
        sw_high_power_en = 1'b0;
        repeat (3) @(negedge core_clk);
        check("lp_back", 1'b1, low_power_select);
    endtask
    task automatic fault;
        fault_event = 1'b1;
        @(negedge core_clk);
        fault_event = 1'b0;
        @(negedge core_clk);
        check("fault_int", 1'b0, int_line_n);
        service(8'h14);
    endtask
    task automatic pin_reset;
        sw_high_power_en = 1'b1;
        module_reset_n = 1'b0;
        repeat (pmc_pkg::RESET_MIN_CYC - 20) @(negedge core_clk);
        module_reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check("short_nrdy", 1'b0, data_not_ready);
        check("short_lp", 1'b0, low_power_select);
        module_reset_n = 1'b0;
        repeat (pmc_pkg::RESET_MIN_CYC + 3) @(negedge core_clk);
        check("rst_nrdy", 1'b1, data_not_ready);
        check("rst_lp", 1'b1, low_power_select);
        check("rst_int", 1'b1, int_line_n);
        sw_high_power_en = 1'b0;
        module_reset_n = 1'b1;
        power_up(1'b1, 1'b0);
    endtask
    task automatic hw_mode;
        init_control_driven = 1'b1;
        init_control_select = 1'b0;
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        power_up(1'b0, 1'b1);
    endtask
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        {module_select_n, module_reset_n} = 2'h3;
        {init_control_select, init_control_driven} = 2'h0;
        {serial_ack_req, serial_sda_low_req, fault_event} = 3'h0;
        {sw_high_power_en, auto_service} = 2'h0;
        service_delay = 8'h00;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        power_up(1'b1, 1'b1);
        serial_gate();
        high_power();
        fault();
        pin_reset();
        hw_mode();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end
endmodule
